// >>> core/pfc_host.v
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defs.vh"

// Operation
// [RULE1] Parameter and main blocks need only supply
// [RULE2] Reads return array, status or identification
// [RULE3] Array data valid while strobes low
// [RULE4] Width select high gives sixteen-bit words
// [RULE5] Byte mode uses line 15 as address
// [RULE6] Status sits on low byte only
// [RULE7] Status latched at later falling strobe
// [RULE8] Status mode after write or erase
// [RULE9] Address bit zero picks identification byte
// [RULE10] Upper identification byte fixed in word mode
// [RULE11] Line nine override serves identification reads
// [RULE12] Command cycle: output high, chip/write low
// [RULE13] Writes only clear bits to zero
// [RULE14] Host raises supply and boot unlock
// [RULE15] Write setup precedes every array write
// [RULE16] FFh returns to array read
// [RULE17] 90h identification, 70h status mode
// [RULE18] 50h clears status bits three to five
// [RULE19] 20h then D0h starts erase
// [RULE20] 40h or 10h is write setup
// [RULE21] B0h suspends erase, limited commands
// [RULE22] Never issue reserved or undefined codes
// [RULE23] Bit seven ready; busy write ignores commands
// [RULE24] Identification mode holds until next command
// [RULE25] Decoder tracks read source and setup
module pfc_host #(
	parameter ADDR_W = 19
) (
	// Clock and reset
	input  wire               clk_i,
	input  wire               rst_i,
	// Wishbone slave
	input  wire               wb_cyc_i,
	input  wire               wb_stb_i,
	input  wire               wb_we_i,
	input  wire [3:0]         wb_adr_i,
	input  wire [3:0]         wb_sel_i,
	input  wire [31:0]        wb_dat_i,
	output reg  [31:0]        wb_dat_o,
	output reg                wb_ack_o,
	// Flash pins
	output reg  [ADDR_W-1:0]  fl_addr_o,
	output reg                fl_ce_n_o,
	output reg                fl_oe_n_o,
	output reg                fl_we_n_o,
	output reg                fl_word_o,
	output reg                fl_wp_o,
	output reg                fl_supply_o,
	output reg                fl_reset_powerdown_n_o,
	output reg                fl_id_override_o,
	input  wire [15:0]        fl_dq_i,
	output reg  [15:0]        fl_dq_o,
	output reg                fl_dq_oe_o
);
	localparam [2:0] S_IDLE = 3'd0, S_SETUP = 3'd1, S_PULSE = 3'd2, S_SAMPLE = 3'd3, S_RECOVER = 3'd4;
	// Counts are worked out as integers, then cut to the counter width on purpose
	localparam integer CYC_SETUP   = `PFC_CYC_SETUP;
	localparam integer CYC_PULSE   = `PFC_CYC_PULSE;
	localparam integer CYC_ACCESS  = `PFC_CYC_ACCESS;
	localparam integer CYC_RECOVER = `PFC_CYC_RECOVER;
	localparam [3:0] T_SETUP   = CYC_SETUP[3:0];
	localparam [3:0] T_PULSE   = CYC_PULSE[3:0];
	localparam [3:0] T_ACCESS  = CYC_ACCESS[3:0];
	localparam [3:0] T_RECOVER = CYC_RECOVER[3:0];

	reg  [31:0]       ctrl_q;
	reg  [ADDR_W:0]   addr_q;
	reg  [15:0]       wdata_q;
	reg  [15:0]       rdata_q;
	reg  [7:0]        sr_q;
	reg  [2:0]        state_q;
	reg  [3:0]        cnt_q;
	reg               wr_q;
	reg               cmd_q;
	reg               done_q;
	reg               suspended_q;
	reg               refused_q;
	wire              legal;
	wire              wb_req;
	wire [7:0]        cmd_code;

	assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign cmd_code = ctrl_q[`PFC_CTRL_CMD_LSB+7:`PFC_CTRL_CMD_LSB];

	pfc_cmd_check u_check (
		.cmd_i       (cmd_code),
		.suspended_i (suspended_q),
		.legal_o     (legal)
	);

	// Wishbone slave: one registered ack per request, a cycle after the strobe
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			ctrl_q   <= `PFC_CTRL_RST;
			addr_q   <= {(ADDR_W+1){1'b0}};
			wdata_q  <= 16'h0000;
			done_q   <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
			if (state_q == S_IDLE && ctrl_q[`PFC_CTRL_GO]) begin
				ctrl_q[`PFC_CTRL_GO] <= 1'b0;
				if (ctrl_q[`PFC_CTRL_CMDMODE] && !legal)
					refused_q <= 1'b1; // [RULE22]
			end
			if (wb_req && wb_we_i) begin
				if (wb_adr_i == `PFC_REG_CTRL) begin
					if (wb_sel_i[0])
						ctrl_q[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1])
						ctrl_q[15:8] <= wb_dat_i[15:8];
					if (wb_sel_i[2])
						ctrl_q[23:16] <= wb_dat_i[23:16];
					if (wb_sel_i[0] && wb_dat_i[`PFC_CTRL_GO]) begin
						done_q    <= 1'b0;
						refused_q <= 1'b0;
					end
				end else if (wb_adr_i == `PFC_REG_ADDR) begin
					addr_q <= wb_dat_i[ADDR_W:0];
				end else if (wb_adr_i == `PFC_REG_DATA) begin
					wdata_q <= wb_dat_i[15:0];
				end
			end
			// Completion wins over a clear written in the same cycle
			if (state_q == S_RECOVER && cnt_q == 4'h0)
				done_q <= 1'b1;
			if (wb_req) begin
				if (wb_adr_i == `PFC_REG_CTRL)
					wb_dat_o <= ctrl_q;
				else if (wb_adr_i == `PFC_REG_ADDR)
					wb_dat_o <= {{(31-ADDR_W){1'b0}}, addr_q};
				else if (wb_adr_i == `PFC_REG_DATA)
					wb_dat_o <= {16'h0000, rdata_q};
				else if (wb_adr_i == `PFC_REG_STAT)
					wb_dat_o <= {16'h0000, sr_q, 4'h0, refused_q, suspended_q, done_q, (state_q != S_IDLE)};
				else
					wb_dat_o <= 32'h0000_0000;
			end
		end
	end

	// Static pins follow control bits
	always @(posedge clk_i) begin
		if (rst_i) begin
			fl_word_o              <= 1'b1;
			fl_wp_o                <= 1'b0;
			fl_supply_o            <= 1'b0;
			fl_reset_powerdown_n_o <= 1'b0;
			fl_id_override_o       <= 1'b0;
		end else begin
			fl_word_o              <= ctrl_q[`PFC_CTRL_WORD]; // [RULE4] [RULE5]
			fl_supply_o            <= ctrl_q[`PFC_CTRL_SUPPLY]; // [RULE14] [RULE1]
			fl_wp_o                <= ctrl_q[`PFC_CTRL_BOOTEN]; // [RULE14]
			fl_reset_powerdown_n_o <= ctrl_q[`PFC_CTRL_RESET];
			fl_id_override_o       <= ctrl_q[`PFC_CTRL_ID]; // [RULE11]
		end
	end

	// Bus cycle engine; strobes fall cycles after chip select, and all rise together
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_q     <= S_IDLE;
			cnt_q       <= 4'h0;
			wr_q        <= 1'b0;
			cmd_q       <= 1'b0;
			fl_ce_n_o   <= 1'b1;
			fl_oe_n_o   <= 1'b1;
			fl_we_n_o   <= 1'b1;
			fl_dq_o     <= 16'h0000;
			fl_dq_oe_o  <= 1'b0;
			fl_addr_o   <= {ADDR_W{1'b0}};
			rdata_q     <= 16'h0000;
			sr_q        <= 8'h00;
			suspended_q <= 1'b0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (ctrl_q[`PFC_CTRL_GO] && (!ctrl_q[`PFC_CTRL_CMDMODE] || legal)) begin
						wr_q      <= ctrl_q[`PFC_CTRL_WR];
						cmd_q     <= ctrl_q[`PFC_CTRL_CMDMODE];
						// Word mode takes the low bits; byte mode takes the upper bits and puts bit 0 on line 15 for data cycles, not command cycles
						fl_addr_o <= ctrl_q[`PFC_CTRL_WORD] ? addr_q[ADDR_W-1:0] : addr_q[ADDR_W:1]; // [RULE5]
						fl_ce_n_o <= 1'b0;
						cnt_q     <= T_SETUP;
						state_q   <= S_SETUP;
						if (ctrl_q[`PFC_CTRL_WR]) begin
							// Command goes on the low byte whatever the width
							if (ctrl_q[`PFC_CTRL_CMDMODE])
								fl_dq_o <= {8'h00, cmd_code}; // [RULE12] [RULE16]
							else if (ctrl_q[`PFC_CTRL_WORD])
								fl_dq_o <= wdata_q; // [RULE4] [RULE15]
							else
								fl_dq_o <= {addr_q[0], 7'h00, wdata_q[7:0]}; // [RULE5]
							fl_dq_oe_o <= 1'b1;
						end else if (!ctrl_q[`PFC_CTRL_WORD]) begin
							fl_dq_o    <= {addr_q[0], 15'h0000}; // [RULE5]
							fl_dq_oe_o <= 1'b1;
						end
					end
				end
				S_SETUP: begin
					if (cnt_q == 4'h0) begin
						if (wr_q)
							fl_we_n_o <= 1'b0; // [RULE12]
						else
							fl_oe_n_o <= 1'b0; // [RULE7]
						cnt_q   <= wr_q ? T_PULSE : T_ACCESS;
						state_q <= S_PULSE;
					end else
						cnt_q <= cnt_q - 4'h1;
				end
				S_PULSE: begin
					if (cnt_q == 4'h0)
						state_q <= S_SAMPLE;
					else
						cnt_q <= cnt_q - 4'h1;
				end
				S_SAMPLE: begin
					if (!wr_q) begin
						// Full-width capture in word mode, low byte in byte mode; status uses low byte only
						rdata_q <= fl_word_o ? fl_dq_i : {8'h00, fl_dq_i[7:0]}; // [RULE2] [RULE3] [RULE6] [RULE9]
						sr_q    <= fl_dq_i[7:0]; // [RULE23]
					end else if (cmd_q) begin
						if (cmd_code == `PFC_CMD_SUSPEND)
							suspended_q <= 1'b1; // [RULE21]
						else if (cmd_code == `PFC_CMD_CONFIRM)
							suspended_q <= 1'b0; // [RULE19]
					end
					// Rising strobe latches the cycle; OE rise releases status for a fresh capture
					fl_we_n_o <= 1'b1; // [RULE15]
					fl_oe_n_o <= 1'b1; // [RULE7]
					fl_ce_n_o <= 1'b1;
					cnt_q     <= T_RECOVER;
					state_q   <= S_RECOVER;
				end
				default: begin
					fl_dq_oe_o <= 1'b0;
					if (cnt_q == 4'h0)
						state_q <= S_IDLE;
					else
						cnt_q <= cnt_q - 4'h1;
				end
			endcase
		end
	end
endmodule // pfc_host

`default_nettype wire

// >>> core/pfc_defs.vh
`ifndef PFC_DEFS_VH
`define PFC_DEFS_VH

// Wishbone register byte offsets
`define PFC_REG_CTRL      4'h0
`define PFC_REG_ADDR      4'h4
`define PFC_REG_DATA      4'h8
`define PFC_REG_STAT      4'hc

// Control register fields
`define PFC_CTRL_GO       0
`define PFC_CTRL_WR       1
`define PFC_CTRL_WORD     2
`define PFC_CTRL_ID       3
`define PFC_CTRL_SUPPLY   4
`define PFC_CTRL_BOOTEN   5
`define PFC_CTRL_RESET    6
`define PFC_CTRL_CMD_LSB  8
`define PFC_CTRL_CMDMODE  16

// Status register fields
`define PFC_STAT_BUSY     0
`define PFC_STAT_RDY      1
`define PFC_STAT_SR_LSB   8

// Reset values
`define PFC_CTRL_RST      32'h0000_0040

// Flash command codes
`define PFC_CMD_READ_ARRAY   8'hff
`define PFC_CMD_IDENTIFY     8'h90
`define PFC_CMD_READ_STATUS  8'h70
`define PFC_CMD_CLEAR_STATUS 8'h50
`define PFC_CMD_ERASE_SETUP  8'h20
`define PFC_CMD_CONFIRM      8'hd0
`define PFC_CMD_WRITE_SETUP  8'h40
`define PFC_CMD_WRITE_SETUP2 8'h10
`define PFC_CMD_SUSPEND      8'hb0

// Strobe timing in ns and derived cycles at 40 MHz
`define PFC_CLK_NS        25
`define PFC_T_SETUP_NS    50
`define PFC_T_PULSE_NS    100
`define PFC_T_ACCESS_NS   80
`define PFC_T_RECOVER_NS  50
`define PFC_CYC_SETUP   ((`PFC_T_SETUP_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_CYC_PULSE   ((`PFC_T_PULSE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_CYC_ACCESS  ((`PFC_T_ACCESS_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS + 1)
`define PFC_CYC_RECOVER ((`PFC_T_RECOVER_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)

`endif

// >>> core/pfc_cmd_check.v
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defs.vh"

// Screens command codes so only the defined set reaches the pins
module pfc_cmd_check (
	// Command in
	input  wire [7:0] cmd_i,
	input  wire       suspended_i,
	// Verdict
	output wire       legal_o
);
	function is_defined;
		input [7:0] c;
		begin
			is_defined = (c == `PFC_CMD_READ_ARRAY) || (c == `PFC_CMD_IDENTIFY) ||
				(c == `PFC_CMD_READ_STATUS) || (c == `PFC_CMD_CLEAR_STATUS) ||
				(c == `PFC_CMD_ERASE_SETUP) || (c == `PFC_CMD_CONFIRM) ||
				(c == `PFC_CMD_WRITE_SETUP) || (c == `PFC_CMD_WRITE_SETUP2) ||
				(c == `PFC_CMD_SUSPEND);
		end
	endfunction

	// While suspended only status, array read and resume are accepted
	assign legal_o = is_defined(cmd_i) && (!suspended_i || (cmd_i == `PFC_CMD_READ_STATUS) ||
		(cmd_i == `PFC_CMD_READ_ARRAY) || (cmd_i == `PFC_CMD_CONFIRM)); // [RULE22] [RULE21]
endmodule // pfc_cmd_check

`default_nettype wire

// >>> verif/pfc_host_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_host_monitor #(
	parameter ADDR_W = 19
) (
	// Clock and reset
	input wire logic              clk_i,
	input wire logic              rst_i,
	// Watched outputs
	input wire logic              wb_ack_o,
	input wire logic [ADDR_W-1:0] fl_addr_o,
	input wire logic              fl_ce_n_o,
	input wire logic              fl_oe_n_o,
	input wire logic              fl_we_n_o,
	input wire logic [15:0]       fl_dq_o,
	input wire logic              fl_dq_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	we_pulse_a: assert property ($fell(fl_we_n_o) |-> !fl_we_n_o [*5])
		else $error("write pulse short");
	oe_pulse_a: assert property ($fell(fl_oe_n_o) |-> !fl_oe_n_o [*5])
		else $error("read pulse short");
	dq_hold_a: assert property (!fl_we_n_o |-> fl_dq_oe_o ##1 (fl_we_n_o || $stable(fl_dq_o) && $stable(fl_addr_o)))
		else $error("write data moved");
	ce_setup_a: assert property ($fell(fl_we_n_o) || $fell(fl_oe_n_o) |-> !$past(fl_ce_n_o, 2))
		else $error("chip select setup");
	reset_idle_a: assert property ($fell(rst_i) |-> fl_ce_n_o && fl_oe_n_o && fl_we_n_o && !fl_dq_oe_o)
		else $error("pins busy after reset");
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	rise_all_a: assert property ($rose(fl_ce_n_o) |-> fl_oe_n_o && fl_we_n_o)
		else $error("strobes rose apart");
	cmd_shape_a: assert property (!fl_we_n_o |-> !fl_ce_n_o && fl_oe_n_o)
		else $error("write cycle shape");
endmodule // pfc_host_monitor
bind pfc_host pfc_host_monitor #(.ADDR_W(ADDR_W)) pfc_host_monitor_i (.clk_i, .rst_i, .wb_ack_o,
	.fl_addr_o, .fl_ce_n_o, .fl_oe_n_o, .fl_we_n_o, .fl_dq_o, .fl_dq_oe_o);
`default_nettype wire

// >>> verif/pfc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_flash_model #(
	// Identity values are arbitrary
	parameter logic [15:0] ID_LO = 16'h213c,
	parameter logic [15:0] ID_HI = 16'h435a
) (
	// Strobes and levels
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic        word_i,
	input  wire logic        supply_i,
	input  wire logic        rst_n_i,
	input  wire logic        idov_i,
	// Bus
	input  wire logic [18:0] addr_i,
	input  wire logic [15:0] dq_i,
	output logic      [15:0] dq_o,
	output logic      [15:0] en_o
);
	logic [15:0] mem [int];
	logic [7:0]  sr, sr_q;
	int          mode, a; // Read source and pending setup
	wire         rd = !ce_n_i && !oe_n_i && we_n_i;
	wire         wr = !ce_n_i && !we_n_i;
	always @* a = word_i ? int'(addr_i) : int'({addr_i, dq_i[15]});
	always @(posedge rd) sr_q = sr;
	// Writes finish at once, so busy is never seen here
	always @(negedge wr or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode = 0;
			sr = 8'h80;
		end else if (mode == 3) begin
			if (supply_i) mem[a] = (mem.exists(a) ? mem[a] : 16'hffff) & dq_i;
			else sr = sr | 8'h18;
			mode = 1;
		end else begin
			case (dq_i[7:0])
				8'hff: mode = 0;
				8'h90: mode = 2;
				8'h70, 8'hb0: mode = 1;
				8'h50: sr = sr & 8'hc7;
				8'h40, 8'h10: mode = 3;
				8'h20: mode = 4;
				8'hd0: begin
					if (mode == 4) mem.delete();
					mode = 1;
				end
				default: ;
			endcase
		end
	end
	always @* begin
		en_o = 16'h0000;
		dq_o = 16'h0000;
		if (rd) begin
			en_o = word_i ? 16'hffff : 16'h00ff;
			if (idov_i || mode == 2) dq_o = addr_i[0] ? ID_HI : ID_LO;
			else if (mode != 0) dq_o = {8'h00, sr_q};
			else dq_o = mem.exists(a) ? mem[a] : 16'hffff;
		end
	end
endmodule // pfc_flash_model
`default_nettype wire

// >>> verif/test_pfc_host.sv
`timescale 1ns/1ps
`default_nettype none
module test_pfc_host;
	localparam logic [31:0] B = 32'h0000_0054; // Word mode, supply on, reset pin released
	localparam logic [31:0] C = 32'h0001_0002;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0]  wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, r, d;
	logic [18:0] fl_addr_o;
	logic        fl_ce_n_o, fl_oe_n_o, fl_we_n_o, fl_word_o, fl_wp_o, fl_supply_o;
	logic        fl_reset_powerdown_n_o, fl_id_override_o, fl_dq_oe_o;
	logic [15:0] fl_dq_i, fl_dq_o, m_dq, m_en, junk;
	logic [15:0] ref_mem [int];
	int          seed, a, mismatches, total_checks;
	pfc_host #(.ADDR_W(19)) pfc_host_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .fl_addr_o, .fl_ce_n_o, .fl_oe_n_o, .fl_we_n_o, .fl_word_o, .fl_wp_o,
		.fl_supply_o, .fl_reset_powerdown_n_o, .fl_id_override_o, .fl_dq_i, .fl_dq_o, .fl_dq_oe_o);
	pfc_flash_model pfc_flash_model_i (.ce_n_i(fl_ce_n_o), .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o),
		.word_i(fl_word_o), .supply_i(fl_supply_o), .rst_n_i(fl_reset_powerdown_n_o), .idov_i(fl_id_override_o),
		.addr_i(fl_addr_o), .dq_i(fl_dq_i), .dq_o(m_dq), .en_o(m_en));
	// Floating lines toggle so a stale value never passes; lines the model drives win
	assign fl_dq_i = (m_dq & m_en) | (~m_en & (fl_dq_oe_o ? fl_dq_o : junk));
	always @(posedge clk_i) junk <= ~junk;
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] dt);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= ad;
		wb_dat_i <= dt;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 40);
		r = wb_dat_o;
		if (n >= 40) begin
			mismatches++;
			$display("FAIL %0t bus acknowledge timeout", $time);
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic fop(input logic [31:0] c);
		int n;
		n = 0;
		wb(1'b1, 4'h0, c | 32'h1);
		do wb(1'b0, 4'hc, 32'h0); while (r[0] !== 1'b0 && ++n < 200);
		if (r[0] !== 1'b0) begin
			mismatches++;
			$display("FAIL %0t flash cycle timeout", $time);
		end
	endtask
	task automatic cmd(input logic [7:0] k);
		fop(B | C | {16'h0, k, 8'h00});
	endtask
	task automatic wrd(input int ad, input logic [15:0] v, input logic [31:0] c);
		wb(1'b1, 4'h8, {16'h0, v});
		wb(1'b1, 4'h4, ad);
		fop(c | 32'h2);
		if (c[4]) ref_mem[ad] = (ref_mem.exists(ad) ? ref_mem[ad] : 16'hffff) & v;
	endtask
	task automatic rd(input int ad, input logic [31:0] c, input logic [15:0] e);
		wb(1'b1, 4'h4, ad);
		fop(c);
		wb(1'b0, 4'h8, 32'h0);
		chk(r[15:0], e);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#(25 * 60000);
		mismatches++;
		final_report;
	end
	initial begin
		{seed, mismatches, total_checks, junk} = {32'd48, 64'd0, 16'h5a5a};
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {4'h8, 8'h0f, 32'h0};
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		a = $random(seed) & 32'h7fffe;
		d = $random(seed);
		rd(a, B, 16'hffff);
		cmd(8'h40);
		wrd(a, d[15:0], B);
		rd(a, B, 16'h0080);
		cmd(8'hff);
		rd(a, B, ref_mem[a]);
		cmd(8'h10);
		wrd(a, d[31:16], B);
		cmd(8'hff);
		rd(a, B, ref_mem[a]);
		$display("array write test done");
		cmd(8'h90);
		rd(a, B, 16'h213c);
		rd(a + 1, B, 16'h435a);
		wb(1'b1, 4'h0, B & ~32'h40);
		rd(a, B, ref_mem[a]);
		cmd(8'hff);
		rd(a + 1, B | 32'h8, 16'h435a);
		rd(a, B, ref_mem[a]);
		$display("identification test done");
		cmd(8'h40);
		wrd(a + 2, 16'h0000, B & ~32'h10);
		rd(0, B, 16'h0098);
		cmd(8'h50);
		cmd(8'h70);
		rd(0, B, 16'h0080);
		wb(1'b1, 4'h0, B | 32'h20);
		chk({15'h0, fl_wp_o}, 16'h0001);
		wb(1'b1, 4'h0, B);
		chk({15'h0, fl_wp_o}, 16'h0000);
		cmd(8'h20);
		cmd(8'hd0);
		ref_mem.delete();
		cmd(8'hff);
		rd(a, B, 16'hffff);
		cmd(8'h40);
		wrd(a + 3, {8'h00, d[7:0]}, B & ~32'h4);
		cmd(8'hff);
		rd(a + 3, B & ~32'h4, {8'h00, d[7:0]});
		rd(a + 2, B & ~32'h4, 16'h00ff);
		cmd(8'h20);
		cmd(8'hd0);
		cmd(8'hb0);
		chk({15'h0, r[2]}, 16'h0001);
		cmd(8'h90);
		chk({15'h0, r[3]}, 16'h0001);
		cmd(8'hd0);
		cmd(8'h00);
		chk({15'h0, r[3]}, 16'h0001);
		$display("command test done");
		final_report;
	end
endmodule // test_pfc_host
`default_nettype wire
